//--- shared/ahcf_pkg.sv
// shared constants and types for the converter host command and flag logic
package ahcf_pkg;
   localparam int AHCF_DATA_W = 18;
   localparam int AHCF_RES_W  = 13;
   localparam int AHCF_CH_W   = 7;
   localparam int AHCF_ADDR_W = 6;

   // avalon register offsets (byte addresses)
   localparam logic [4:0] OFS_COMMAND = 5'h00;
   localparam logic [4:0] OFS_ACC_IN  = 5'h04;
   localparam logic [4:0] OFS_ACC_OUT = 5'h08;
   localparam logic [4:0] OFS_FLAGS   = 5'h0C;
   localparam logic [4:0] OFS_CHANNEL = 5'h10;
   localparam logic [4:0] OFS_TRAP    = 5'h14;

   // command codes written to OFS_COMMAND
   localparam logic [2:0] CMD_CLEAR_FLAGS = 3'h1;
   localparam logic [2:0] CMD_CONVERT     = 3'h2;
   localparam logic [2:0] CMD_READ_RESULT = 3'h3;
   localparam logic [2:0] CMD_READ_STATUS = 3'h4;
   localparam logic [2:0] CMD_FLAG_SKIP   = 3'h5;

   // status register fields
   localparam int STAT_EXT_SYNC_BIT = 8;
   localparam int STAT_ADD_MEM_BIT  = 9;
   localparam int STAT_SEQ_BIT      = 10;

   // flag bit positions
   localparam int FLG_DONE = 0;
   localparam int FLG_PRIO = 1;
   localparam int FLG_DCH  = 2;
   localparam int FLG_MEM  = 3;
   localparam int FLG_WC   = 4;

   localparam logic [AHCF_DATA_W-1:0] STATUS_RST  = 18'h00000;
   localparam logic [AHCF_CH_W-1:0]   CHANNEL_RST = 7'h00;
   localparam logic [AHCF_ADDR_W-1:0] TRAP_RST    = 6'h00;

   // conversion timing
   localparam int CONV_TIME_NS  = 1000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES = 4;

   typedef struct packed {
      logic [4:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } ahcf_av_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } ahcf_av_rsp_t;

   typedef enum logic [1:0] {
      CV_IDLE   = 2'b00,
      CV_SETTLE = 2'b01,
      CV_RUN    = 2'b10
   } ahcf_conv_st_t;
endpackage

//--- core/ahcf_top.sv
// host command, flag, buffer and priority request logic of the converter
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module ahcf_top
   import ahcf_pkg::*;
#(
   parameter int CONV_CYC = ahcf_pkg::CONV_CYCLES
) (
   // clock and reset
   input  wire logic                    CORE_CLK,
   input  wire logic                    RESET_N,
   // avalon-mm slave
   input  wire ahcf_pkg::ahcf_av_req_t  AV_REQ,
   output      ahcf_pkg::ahcf_av_rsp_t  AV_RSP,
   // converter side
   input  wire logic [12:0]             CONV_RESULT,
   output      logic                    CONV_START,
   output      logic [6:0]              CHANNEL_SELECT,
   output      logic                    ADD_MEM_MODE,
   // io bus signals from the host, asynchronous
   input  wire logic                    IO_SYNC,
   input  wire logic                    CONVERT_PULSE,
   input  wire logic                    PRIO_CHAIN_IN,
   input  wire logic                    PRIO_GRANT,
   input  wire logic                    TRAP_ADDR_GATE,
   input  wire logic                    DCH_EVENT,
   input  wire logic                    MEM_EVENT,
   input  wire logic                    WC_EVENT,
   // io bus signals toward the host
   output      logic                    PRIO_REQUEST_DRV,
   output      logic                    PRIO_CHAIN_OUT,
   output      logic [5:0]              TRAP_ADDR,
   output      logic                    SKIP_REQ,
   output      logic                    DONE_PULSE
);
   import ahcf_pkg::*;

   initial begin
      if (CONV_CYC < 1 || CONV_CYC > 65535) $error("CONV_CYC out of range");
   end

   // three-stage synchronisers for host-side inputs
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_r, s2_r, s3_r, pin_r;
   assign pin_raw = {WC_EVENT, MEM_EVENT, DCH_EVENT, TRAP_ADDR_GATE,
                     PRIO_GRANT, PRIO_CHAIN_IN, CONVERT_PULSE, IO_SYNC};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge CORE_CLK) begin
            if (!RESET_N) begin
               s1_r[gi]  <= 1'b0;
               s2_r[gi]  <= 1'b0;
               s3_r[gi]  <= 1'b0;
               pin_r[gi] <= 1'b0;
            end else begin
               s1_r[gi] <= pin_raw[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               // change accepted only once stages two and three agree
               if (s2_r[gi] == s3_r[gi]) begin
                  pin_r[gi] <= s3_r[gi];
               end
            end
         end
      end
   endgenerate

   logic pin_prev_r [NSYNC];
   logic sync_rise, convert_pulse_rise, dch_rise, mem_rise, wc_rise;
   always_ff @(posedge CORE_CLK) begin
      for (int i = 0; i < NSYNC; i++) begin
         pin_prev_r[i] <= RESET_N ? pin_r[i] : 1'b0;
      end
   end
   assign sync_rise = pin_r[0] & ~pin_prev_r[0];
   assign convert_pulse_rise = pin_r[1] & ~pin_prev_r[1];
   assign dch_rise  = pin_r[5] & ~pin_prev_r[5];
   assign mem_rise  = pin_r[6] & ~pin_prev_r[6];
   assign wc_rise   = pin_r[7] & ~pin_prev_r[7];

   // avalon decode: one wait state, answer on the second edge
   logic        ack_r;
   logic [31:0] rdata_r;
   logic        acc_wr, cmd_wr;
   logic [2:0]  cmd;
   logic [17:0] acc_in_r;
   logic [17:0] acc_out_r;
   logic [17:0] status_r;
   logic [12:0] result_buffer_r;
   logic [6:0]  channel_r;
   logic [5:0]  trap_r;
   logic [4:0]  flags_r;
   logic        skip_r;
   logic        done_evt;
   logic        req_active;

   assign req_active = (AV_REQ.read | AV_REQ.write) & ~ack_r;
   assign cmd_wr     = AV_REQ.write & ack_r & (AV_REQ.address == OFS_COMMAND);
   assign acc_wr     = AV_REQ.write & ack_r & (AV_REQ.address == OFS_ACC_IN);
   assign cmd        = AV_REQ.writedata[2:0];

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req_active;
      end
   end

   // waitrequest has its own flop so the port sees no gate after it
   logic wait_r;
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~req_active;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         rdata_r <= 32'h00000000;
      end else if (AV_REQ.read & ~ack_r) begin
         unique case (AV_REQ.address)
            OFS_ACC_IN:  rdata_r <= {14'h0000, acc_in_r};
            OFS_ACC_OUT: rdata_r <= {14'h0000, acc_out_r};
            OFS_FLAGS:   rdata_r <= {26'h0000000, skip_r, flags_r};
            OFS_CHANNEL: rdata_r <= {25'h0000000, channel_r};
            OFS_TRAP:    rdata_r <= {26'h0000000, trap_r};
            default:     rdata_r <= 32'h00000000;
         endcase
      end
   end

   logic trap_wr, chan_wr;
   assign trap_wr = AV_REQ.write & ack_r & (AV_REQ.address == OFS_TRAP);
   assign chan_wr = AV_REQ.write & ack_r & (AV_REQ.address == OFS_CHANNEL);

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         acc_in_r <= STATUS_RST;
      end else if (acc_wr) begin
         acc_in_r <= AV_REQ.writedata[17:0];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         trap_r <= TRAP_RST;
      end else if (trap_wr) begin
         trap_r <= AV_REQ.writedata[5:0];
      end
   end

   // status register and sync source
   logic ext_sync;
   assign ext_sync = status_r[STAT_EXT_SYNC_BIT];
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         status_r <= STATUS_RST;
      end else if (cmd_wr && cmd == CMD_CONVERT) begin
         status_r <= acc_in_r;
      end
   end

   // accumulator return path
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         acc_out_r <= STATUS_RST;
      end else if (cmd_wr && cmd == CMD_READ_RESULT) begin
         acc_out_r <= {5'h00, result_buffer_r};
      end else if (cmd_wr && cmd == CMD_READ_STATUS) begin
         acc_out_r <= status_r;
      end
   end

   // conversion sequencer
   ahcf_conv_st_t cv_r;
   logic [15:0]   cv_cnt_r;
   logic          start_req;
   assign start_req = (cmd_wr && cmd == CMD_CONVERT) || (convert_pulse_rise && !ext_sync);
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         cv_r       <= CV_IDLE;
         cv_cnt_r   <= 16'h0000;
         CONV_START <= 1'b0;
         DONE_PULSE <= 1'b0;
      end else begin
         CONV_START <= 1'b0;
         DONE_PULSE <= 1'b0;
         unique case (cv_r)
            CV_IDLE: begin
               if (start_req) begin
                  cv_r     <= CV_SETTLE;
                  cv_cnt_r <= 16'(SETTLE_CYCLES - 1);
               end
            end
            CV_SETTLE: begin
               // let status and channel settle before sampling
               if (cv_cnt_r == 16'h0000) begin
                  cv_r       <= CV_RUN;
                  cv_cnt_r   <= 16'(CONV_CYC - 1);
                  CONV_START <= 1'b1;
               end else begin
                  cv_cnt_r <= cv_cnt_r - 16'h0001;
               end
            end
            CV_RUN: begin
               if (cv_cnt_r == 16'h0000) begin
                  cv_r       <= CV_IDLE;
                  DONE_PULSE <= 1'b1;
               end else begin
                  cv_cnt_r <= cv_cnt_r - 16'h0001;
               end
            end
            default: cv_r <= CV_IDLE;
         endcase
      end
   end
   assign done_evt = DONE_PULSE;

   // result buffer loads on done only
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         result_buffer_r <= 13'h0000;
      end else if (done_evt) begin
         result_buffer_r <= CONV_RESULT;
      end
   end

   // channel address counter
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         channel_r <= CHANNEL_RST;
      end else if (chan_wr) begin
         channel_r <= AV_REQ.writedata[6:0];
      end else if (done_evt && status_r[STAT_SEQ_BIT]) begin
         channel_r <= channel_r + 7'h01;
      end
   end

   // flags: a set in the clearing cycle wins
   logic [4:0] flag_set, flag_clr;
   always_comb begin
      flag_set           = 5'h00;
      flag_set[FLG_DONE] = done_evt;
      flag_set[FLG_PRIO] = done_evt;
      flag_set[FLG_DCH]  = dch_rise;
      flag_set[FLG_MEM]  = mem_rise;
      flag_set[FLG_WC]   = wc_rise;
      flag_clr           = 5'h00;
      if (cmd_wr && cmd == CMD_CLEAR_FLAGS) begin
         flag_clr = 5'h1F;
      end
      if (cmd_wr && (cmd == CMD_CONVERT || cmd == CMD_READ_RESULT)) begin
         flag_clr[FLG_DONE] = 1'b1;
      end
      if (pin_r[3] && PRIO_CHAIN_OUT == 1'b0 && PRIO_REQUEST_DRV) begin
         flag_clr[FLG_PRIO] = 1'b1;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         flags_r <= 5'h00;
      end else begin
         flags_r <= (flags_r & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         skip_r <= 1'b0;
      end else if (cmd_wr && cmd == CMD_FLAG_SKIP) begin
         skip_r <= |flags_r;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         SKIP_REQ <= 1'b0;
      end else begin
         SKIP_REQ <= cmd_wr && cmd == CMD_FLAG_SKIP && (|flags_r);
      end
   end

   // priority request, chain and trap address
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         PRIO_REQUEST_DRV <= 1'b0;
      end else if (sync_rise) begin
         PRIO_REQUEST_DRV <= flags_r[FLG_PRIO];
      end
   end

   // chain passes the synchronised chain input, blocked from one cycle after the request rises, like any registered output
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         PRIO_CHAIN_OUT <= 1'b0;
      end else begin
         PRIO_CHAIN_OUT <= pin_r[2] & ~PRIO_REQUEST_DRV;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         TRAP_ADDR <= 6'h00;
      end else begin
         TRAP_ADDR <= (pin_r[4] && PRIO_REQUEST_DRV) ? trap_r : 6'h00;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         CHANNEL_SELECT <= CHANNEL_RST;
         ADD_MEM_MODE   <= 1'b0;
      end else begin
         CHANNEL_SELECT <= channel_r;
         ADD_MEM_MODE   <= status_r[STAT_ADD_MEM_BIT];
      end
   end

   assign AV_RSP.readdata    = rdata_r;
   assign AV_RSP.waitrequest = wait_r;
endmodule

//--- tb/ahcf_top_sva.sv
// assertion checker for the converter host command and flag logic
`timescale 1ns/100ps
module ahcf_chk
   import ahcf_pkg::*;
#(
   parameter int CONV_CYC = 250
) (
   // clock and reset
   input wire logic                   CORE_CLK,
   input wire logic                   RESET_N,
   // register bus
   input wire ahcf_pkg::ahcf_av_req_t AV_REQ,
   input wire ahcf_pkg::ahcf_av_rsp_t AV_RSP,
   // converter and io bus
   input wire logic                   CONV_START,
   input wire logic [6:0]             CHANNEL_SELECT,
   input wire logic                   ADD_MEM_MODE,
   input wire logic                   IO_SYNC,
   input wire logic                   PRIO_REQUEST_DRV,
   input wire logic                   PRIO_CHAIN_OUT,
   input wire logic [5:0]             TRAP_ADDR,
   input wire logic                   SKIP_REQ,
   input wire logic                   DONE_PULSE
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   localparam int DMIN = CONV_CYC - 1;
   localparam int DMAX = CONV_CYC + 3;
   logic       acc, cmd_wr, cv_wr, sk_wr, ch_wr;
   logic [3:0] sync_age_r;
   assign acc    = AV_REQ.read | AV_REQ.write;
   assign cmd_wr = AV_REQ.write & (AV_REQ.address == OFS_COMMAND) & ~AV_RSP.waitrequest;
   assign cv_wr  = cmd_wr & (AV_REQ.writedata[2:0] == CMD_CONVERT);
   assign sk_wr  = cmd_wr & (AV_REQ.writedata[2:0] == CMD_FLAG_SKIP);
   assign ch_wr  = AV_REQ.write & (AV_REQ.address == OFS_CHANNEL);
   // saturates so a long gap never looks like a fresh sync
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N || IO_SYNC) sync_age_r <= 4'h0;
      else if (sync_age_r != 4'hF) sync_age_r <= sync_age_r + 4'h1;
   end
   sequence s_take; $rose(acc); endsequence
   sequence s_ack; !AV_RSP.waitrequest ##1 AV_RSP.waitrequest; endsequence
   a_wait_one: assert property (s_take |=> s_ack)
      else $error("bus answer not after one wait state");
   a_wait_idle: assert property (!acc |-> AV_RSP.waitrequest)
      else $error("waitrequest low without a request");
   a_chain_break: assert property (PRIO_REQUEST_DRV && $past(PRIO_REQUEST_DRV) |-> !PRIO_CHAIN_OUT)
      else $error("chain passed on while requesting");
   a_req_sync: assert property ($changed(PRIO_REQUEST_DRV) |-> sync_age_r <= 4'h8)
      else $error("request changed away from sync");
   a_trap_gate: assert property (TRAP_ADDR != 6'h00 |-> PRIO_REQUEST_DRV || $past(PRIO_REQUEST_DRV))
      else $error("trap address driven without request");
   a_start_done: assert property ($rose(CONV_START) |-> ##[DMIN:DMAX] DONE_PULSE)
      else $error("no done pulse after start");
   a_skip_cause: assert property (SKIP_REQ |-> $past(sk_wr) || $past(sk_wr, 2) || $past(sk_wr, 3))
      else $error("skip request without skip command");
   a_mode_cause: assert property ($changed(ADD_MEM_MODE) |-> $past(cv_wr) || $past(cv_wr, 2))
      else $error("add mode changed without convert");
   a_seq_step: assert property ($changed(CHANNEL_SELECT) && !$past(ch_wr) && !$past(ch_wr, 2)
      |-> CHANNEL_SELECT == $past(CHANNEL_SELECT) + 7'h01)
      else $error("channel moved other than by one");
endmodule
bind ahcf_top ahcf_chk #(.CONV_CYC(CONV_CYC)) u_chk (
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .AV_REQ(AV_REQ), .AV_RSP(AV_RSP),
   .CONV_START(CONV_START), .CHANNEL_SELECT(CHANNEL_SELECT), .ADD_MEM_MODE(ADD_MEM_MODE),
   .IO_SYNC(IO_SYNC), .PRIO_REQUEST_DRV(PRIO_REQUEST_DRV), .PRIO_CHAIN_OUT(PRIO_CHAIN_OUT),
   .TRAP_ADDR(TRAP_ADDR), .SKIP_REQ(SKIP_REQ), .DONE_PULSE(DONE_PULSE));

//--- tb/ahcf_host_model.sv
// host io bus and converter stand-in facing the converter logic
`timescale 1ns/100ps
module ahcf_host_model #(
   parameter int SYNC_PER = 250
) (
   // clock and reset
   input wire logic   clk,
   input wire logic   rst_n,
   // from the device
   input wire logic   conv_start,
   input wire logic   done_pulse,
   input wire logic   prio_request_drv,
   // toward the device
   output logic       io_sync,
   output logic       prio_grant,
   output logic       trap_addr_gate,
   output logic [12:0] conv_result
);
   // two-state so every output is defined from time zero
   int        cnt_r;
   bit        gnt_r;
   bit        valid_r;
   bit [12:0] res_r;
   always_ff @(posedge clk) begin
      cnt_r <= (!rst_n || cnt_r == SYNC_PER - 1) ? 0 : cnt_r + 1;
   end
   // two cycles wide so the device synchroniser cannot miss it
   assign io_sync = rst_n && cnt_r < 2;
   always_ff @(posedge clk) begin
      gnt_r <= rst_n && prio_request_drv === 1'b1;
   end
   assign prio_grant     = gnt_r;
   assign trap_addr_gate = gnt_r;
   always_ff @(posedge clk) begin
      if (!rst_n) valid_r <= 1'b0;
      else if (conv_start === 1'b1) valid_r <= 1'b1;
      else if (done_pulse === 1'b1) valid_r <= 1'b0;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) res_r <= 13'h0000;
      else if (conv_start === 1'b1) res_r <= res_r + 13'h0111;
   end
   // outside a run the output no longer holds the last value
   assign conv_result = valid_r ? res_r : ~res_r;
endmodule

//--- tb/ahcf_top_tb_top.sv
// self-checking bench for the converter host command and flag logic
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module ahcf_top_tb_top;
   import ahcf_pkg::*;
   typedef struct {bit wr; logic [4:0] a; logic [31:0] d;} ahcf_row_t;
   ahcf_row_t rows[8] = '{'{1, OFS_CHANNEL, 32'h7F}, '{0, OFS_CHANNEL, 32'h7F},
      '{1, OFS_TRAP, 32'h2A}, '{0, OFS_TRAP, 32'h2A}, '{1, 5'h18, 32'h55},
      '{0, 5'h18, 32'h0}, '{1, OFS_ACC_IN, 32'h600}, '{0, OFS_ACC_IN, 32'h600}};
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   ahcf_av_req_t req = '0;
   ahcf_av_rsp_t rsp;
   logic         cvp = 1'b0;
   logic         chin = 1'b1;
   logic [2:0]   ev = 3'h0;
   logic         sync, grant, gate, start, done, preq, pchain, skip, amm;
   logic [12:0]  res;
   logic [6:0]   ch;
   logic [5:0]   trap;
   logic [31:0]  q;
   int           num_errors = 0, compares = 0, ndone = 0, nskip = 0, n, k;
   always #2 clk = ~clk;
   ahcf_top #(.CONV_CYC(5)) dut (
      .CORE_CLK(clk), .RESET_N(rst_n), .AV_REQ(req), .AV_RSP(rsp), .CONV_RESULT(res),
      .CONV_START(start), .CHANNEL_SELECT(ch), .ADD_MEM_MODE(amm), .IO_SYNC(sync),
      .CONVERT_PULSE(cvp), .PRIO_CHAIN_IN(chin), .PRIO_GRANT(grant), .TRAP_ADDR_GATE(gate),
      .DCH_EVENT(ev[0]), .MEM_EVENT(ev[1]), .WC_EVENT(ev[2]), .PRIO_REQUEST_DRV(preq),
      .PRIO_CHAIN_OUT(pchain), .TRAP_ADDR(trap), .SKIP_REQ(skip), .DONE_PULSE(done));
   ahcf_host_model #(.SYNC_PER(20)) host (
      .clk(clk), .rst_n(rst_n), .conv_start(start), .done_pulse(done),
      .prio_request_drv(preq), .io_sync(sync), .prio_grant(grant),
      .trap_addr_gate(gate), .conv_result(res));
   always @(posedge clk) begin
      if (done === 1'b1) ndone++;
      if (skip === 1'b1) nskip++;
   end
   task automatic stop_test;
      if (num_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // entered just after a clock edge; request held until waitrequest low
   task automatic av(input bit wr, input logic [4:0] a, input logic [31:0] d);
      int t;
      t = 0;
      req <= '{address: a, read: !wr, write: wr, writedata: d};
      do begin @(posedge clk); t++; end while (rsp.waitrequest !== 1'b0 && t < 40);
      if (t == 40) num_errors++;
      q = rsp.readdata;
      req <= '0;
      @(posedge clk);
   endtask
   task automatic cmd(input logic [2:0] c);
      av(1, OFS_COMMAND, {29'h0, c});
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic wait_req(input logic lvl);
      k = 0;
      while (preq !== lvl && k < 80) begin @(posedge clk); k++; end
   endtask
   task automatic pulse;
      cvp <= 1'b1;
      idle(3);
      cvp <= 1'b0;
      idle(30);
   endtask
   initial begin
      #100000;
      num_errors++;
      stop_test;
   end
   initial begin
      idle(20);
      `CHK({ch, amm, preq, skip, done, rsp.waitrequest}, 12'h001)
      rst_n <= 1'b1;
      idle(2);
      foreach (rows[i]) begin
         av(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) `CHK(q, rows[i].d)
      end
      `CHK(ch, 7'h7F)
      n = ndone;
      cmd(CMD_CONVERT);
      // request lasts one sync period only, so catch it as it rises
      wait_req(1'b1);
      `CHK(preq, 1'b1)
      `CHK(ndone - n, 1)
      `CHK({amm, ch}, 8'h80)
      av(0, OFS_FLAGS, 0);
      `CHK(q[0], 1'b1)
      `CHK(q[1], 1'b1)
      idle(2);
      `CHK(pchain, 1'b0)
      idle(8);
      `CHK(trap, 6'h2A)
      wait_req(1'b0);
      `CHK(preq, 1'b0)
      idle(10);
      `CHK({pchain, trap}, 7'h40)
      cmd(CMD_READ_STATUS);
      av(0, OFS_ACC_OUT, 0);
      `CHK(q, 32'h600)
      av(0, OFS_FLAGS, 0);
      `CHK(q[0], 1'b1)
      n = nskip;
      cmd(CMD_FLAG_SKIP);
      idle(4);
      `CHK(nskip - n, 1)
      cmd(CMD_READ_RESULT);
      av(0, OFS_ACC_OUT, 0);
      `CHK(q, 32'h111)
      av(0, OFS_FLAGS, 0);
      `CHK(q[0], 1'b0)
      ev <= 3'h7;
      idle(3);
      ev <= 3'h0;
      idle(10);
      av(0, OFS_FLAGS, 0);
      `CHK(q[4:2], 3'h7)
      cmd(CMD_CLEAR_FLAGS);
      av(0, OFS_FLAGS, 0);
      `CHK(q[4:0], 5'h00)
      n = nskip;
      cmd(CMD_FLAG_SKIP);
      idle(4);
      `CHK(nskip - n, 0)
      n = ndone;
      pulse();
      `CHK(ndone - n, 1)
      `CHK(ch, 7'h01)
      cmd(CMD_READ_RESULT);
      av(0, OFS_ACC_OUT, 0);
      `CHK(q, 32'h222)
      av(1, OFS_ACC_IN, 32'h100);
      cmd(CMD_CONVERT);
      idle(30);
      `CHK(amm, 1'b0)
      n = ndone;
      pulse();
      `CHK(ndone - n, 0)
      chin <= 1'b0;
      idle(8);
      `CHK(pchain, 1'b0)
      // second reset, applied while no conversion is running
      rst_n <= 1'b0;
      idle(5);
      `CHK({ch, amm, preq, skip, done, rsp.waitrequest}, 12'h001)
      rst_n <= 1'b1;
      idle(2);
      av(0, OFS_CHANNEL, 0);
      `CHK(q, 32'h0)
      stop_test;
   end
endmodule
